/* design/wdc_pkg.sv */
// wdc_pkg: constants and carrier types of the watchdog down counter
// Functional notes
// - A reload write changes the counter only while the load-permit control bit is 1.
// - When the countdown reaches zero the block raises the timeout event, and also a reset request when the reset action is chosen.
// - The counter is 32 bits wide and the count register reads its present value.
// - Out of reset the timeout period is 2,000 ms without any software setup.
// - The control register chooses system reset or periodic interrupt as the timeout action.
package wdc_pkg;

  // clock and timeout
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned TIMEOUT_MS  = 2000;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
  // reset count spans 0xFFFF ticks; round the tick down so 2 s is not exceeded
  localparam int unsigned TICKS_RESET = 32'h0001_0000;
  localparam int unsigned TICK_DIV    = TIMEOUT_CYC / TICKS_RESET;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFF_RELOAD  = 8'h00;
  localparam logic [7:0]  OFF_COUNT   = 8'h04;
  localparam logic [7:0]  OFF_CONTROL = 8'h08;
  localparam logic [7:0]  OFF_STATUS  = 8'h0C;
  localparam logic [7:0]  OFF_CLEAR   = 8'h10;
  localparam logic [7:0]  OFF_ENABLE  = 8'h14;

  localparam logic [31:0] RST_RELOAD  = 32'h0000_0000;
  localparam logic [31:0] RST_COUNT   = 32'h0000_FFFF;
  localparam logic [31:0] RST_CONTROL = 32'h0000_805C;
  localparam logic [0:0]  RST_STATUS  = 1'h0;
  localparam logic [0:0]  RST_ENABLE  = 1'h0;

  // control word fields
  localparam int          CON_SEL_LSB = 2;
  localparam int          CON_SEL_W   = 3;
  localparam int          CON_PERMIT  = 5;
  localparam int          CON_ACT_RST = 6;
  localparam int          CON_RUN     = 15;
  localparam logic [31:0] CON_MASK    = 32'h0000_807C;
  localparam logic [2:0]  SEL_TIMEOUT = 3'h7;

  // status, clear and enable layout
  localparam int          NUM_EVENTS  = 1;
  localparam int          EV_TIMEOUT  = 0;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic       run;
    logic       restart;
    logic [2:0] sel;
  } wdc_presc_ctl_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } wdc_presc_state_t;

  typedef struct packed {
    logic [31:0]           reload;
    logic [31:0]           count;
    logic [31:0]           control;
    logic [NUM_EVENTS-1:0] status;
    logic [NUM_EVENTS-1:0] enable;
    logic [31:0]           rdata;
    logic                  rst_req;
    logic                  booted;
  } wdc_state_t;

endpackage

/* design/wdc_prescaler.sv */
// wdc_prescaler: tick generator for the watchdog count clock
`timescale 1ns/10ps
`default_nettype none
module wdc_prescaler #(
  parameter int unsigned TICK_DIV = wdc_pkg::TICK_DIV
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // control from the register bank
  input  wire wdc_pkg::wdc_presc_ctl_t ctl,
  // one-cycle count pulse
  output logic                         tick
);

  wdc_pkg::wdc_presc_state_t s_q;
  wdc_pkg::wdc_presc_state_t s_d;
  logic [31:0]               div;

  // select 0..6 divides by a power of two, select 7 gives the reset timeout
  always_comb begin
    if (ctl.sel == wdc_pkg::SEL_TIMEOUT) begin
      div = (TICK_DIV == 0) ? 32'h0000_0001 : 32'(TICK_DIV);
    end else begin
      div = 32'h0000_0001 << ctl.sel;
    end
  end

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (!ctl.run || ctl.restart) begin
      s_d.cnt = 32'h0000_0000;
    end else if (s_q.cnt >= div - 32'h0000_0001) begin
      s_d.cnt  = 32'h0000_0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

  chk_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
    tick && div > 32'h0000_0001 && $stable(ctl.sel) |=> !tick)
    else $error("prescaler tick came on two adjacent cycles");

endmodule
`default_nettype wire

/* design/wdc_top.sv */
// wdc_top: watchdog down counter with APB register bank and interrupt
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module wdc_top #(
  parameter int unsigned TIMEOUT_CYC = wdc_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                      REF_CLK,
  input  wire logic                      RESET_N,
  // apb slave
  input  wire logic                      PSEL,
  input  wire logic                      PENABLE,
  input  wire logic                      PWRITE,
  input  wire logic [wdc_pkg::ADDR_W-1:0] PADDR,
  input  wire logic [31:0]               PWDATA,
  output logic [31:0]                    PRDATA,
  output logic                           PREADY,
  output logic                           PSLVERR,
  // timeout actions
  output logic                           IRQ,
  output logic                           RST_REQ
);

  localparam int unsigned TICK_DIV = TIMEOUT_CYC / wdc_pkg::TICKS_RESET;
  localparam int          NUM_EV   = wdc_pkg::NUM_EVENTS;
  // a zero divide runs as one, the same as in the prescaler
  localparam int unsigned EFF_DIV  = (TICK_DIV == 0) ? 1 : TICK_DIV;
  // edges from reset release to the reset request when software never touches it
  localparam logic [31:0] DEFAULT_EXPIRY = 32'(wdc_pkg::RST_COUNT * EFF_DIV + 1);

  wdc_pkg::wdc_state_t     s_q;
  wdc_pkg::wdc_state_t     s_d;
  wdc_pkg::wdc_presc_ctl_t presc_ctl;
  logic                    tick;

  // bus decode
  logic                    setup_rd;
  logic                    acc_wr;
  logic                    mapped;
  logic                    wr_reload;
  logic                    wr_control;
  logic                    wr_clear;
  logic                    wr_enable;
  logic [31:0]             rd_mux;

  // counter decode
  logic                    run;
  logic                    permit;
  logic                    act_reset;
  logic                    load_now;
  logic                    count_step;
  logic [NUM_EV-1:0]       ev_set;
  logic [NUM_EV-1:0]       ev_clr;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  always_comb begin
    unique case (PADDR)
      wdc_pkg::OFF_RELOAD,
      wdc_pkg::OFF_COUNT,
      wdc_pkg::OFF_CONTROL,
      wdc_pkg::OFF_STATUS,
      wdc_pkg::OFF_CLEAR,
      wdc_pkg::OFF_ENABLE: mapped = 1'b1;
      default:             mapped = 1'b0;
    endcase
  end

  // zero wait states; read data is captured in the setup cycle
  assign PREADY     = 1'b1;
  assign PSLVERR    = PSEL & PENABLE & ~mapped;
  assign setup_rd   = PSEL & ~PENABLE & ~PWRITE;
  assign acc_wr     = PSEL & PENABLE & PWRITE & mapped;
  assign wr_reload  = acc_wr & (PADDR == wdc_pkg::OFF_RELOAD);
  assign wr_control = acc_wr & (PADDR == wdc_pkg::OFF_CONTROL);
  assign wr_clear   = acc_wr & (PADDR == wdc_pkg::OFF_CLEAR);
  assign wr_enable  = acc_wr & (PADDR == wdc_pkg::OFF_ENABLE);

  // write-only registers read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (PADDR)
      wdc_pkg::OFF_COUNT:   rd_mux = s_q.count;
      wdc_pkg::OFF_CONTROL: rd_mux = s_q.control;
      wdc_pkg::OFF_STATUS:  rd_mux[NUM_EV-1:0] = s_q.status;
      wdc_pkg::OFF_ENABLE:  rd_mux[NUM_EV-1:0] = s_q.enable;
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // control fields

  assign run       = s_q.control[wdc_pkg::CON_RUN];
  assign permit    = s_q.control[wdc_pkg::CON_PERMIT];
  assign act_reset = s_q.control[wdc_pkg::CON_ACT_RST];
  assign load_now  = wr_reload & permit;
  // once a reset is requested the count stops stepping; until system reset only a permitted reload write changes it
  assign count_step = run & tick & ~wr_reload & ~s_q.rst_req;

  always_comb begin
    presc_ctl.run     = run & ~s_q.rst_req;
    presc_ctl.restart = load_now;
    presc_ctl.sel     = s_q.control[wdc_pkg::CON_SEL_LSB +: wdc_pkg::CON_SEL_W];
  end

  wdc_prescaler #(
    .TICK_DIV (TICK_DIV)
  ) u_prescaler (
    .clk   (REF_CLK),
    .rst_n (RESET_N),
    .ctl   (presc_ctl),
    .tick  (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d        = s_q;
    s_d.booted = 1'b1;
    ev_set     = '0;
    ev_clr     = '0;

    if (setup_rd) begin
      s_d.rdata = rd_mux;
    end

    if (wr_control) begin
      s_d.control = PWDATA & wdc_pkg::CON_MASK;
    end
    if (wr_enable) begin
      s_d.enable = PWDATA[NUM_EV-1:0];
    end
    if (wr_clear) begin
      ev_clr = PWDATA[NUM_EV-1:0];
    end

    // the stored reload value is kept even when the load is not permitted
    if (wr_reload) begin
      s_d.reload = PWDATA;
      if (permit) begin
        s_d.count = PWDATA;
      end
    end else if (count_step) begin
      if (s_q.count == 32'h0000_0001) begin
        s_d.count                  = 32'h0000_0000;
        ev_set[wdc_pkg::EV_TIMEOUT] = 1'b1;
        s_d.rst_req                = act_reset;
      end else if (s_q.count == 32'h0000_0000) begin
        // periodic mode restarts from the reload value
        if (!act_reset) begin
          s_d.count = s_q.reload;
        end
      end else begin
        s_d.count = s_q.count - 32'h0000_0001;
      end
    end

    // a new event beats a clear in the same cycle
    s_d.status = (s_q.status & ~ev_clr) | ev_set;
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q.reload  <= wdc_pkg::RST_RELOAD;
      s_q.count   <= wdc_pkg::RST_COUNT;
      s_q.control <= wdc_pkg::RST_CONTROL;
      s_q.status  <= wdc_pkg::RST_STATUS;
      s_q.enable  <= wdc_pkg::RST_ENABLE;
      s_q.rdata   <= 32'h0000_0000;
      s_q.rst_req <= 1'b0;
      s_q.booted  <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign PRDATA  = s_q.rdata;
  assign IRQ     = |(s_q.status & s_q.enable);
  assign RST_REQ = s_q.rst_req;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_load_blocked: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    wr_reload && !permit |=> s_q.count == $past(s_q.count))
    else $error("reload write changed the count without permission");

  chk_load_taken: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    wr_reload && permit |=> s_q.count == $past(PWDATA))
    else $error("permitted reload write did not load the count");

  chk_timeout_event: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    count_step && s_q.count == 32'h0000_0001
    |=> s_q.count == 32'h0000_0000 && s_q.status[wdc_pkg::EV_TIMEOUT] ##1 IRQ || !s_q.enable[0])
    else $error("timeout did not raise the event");

  chk_reset_action: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    count_step && s_q.count == 32'h0000_0001 && act_reset |=> RST_REQ [*3])
    else $error("reset action was not requested and held");

  chk_periodic_reload: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    count_step && s_q.count == 32'h0000_0000 && !act_reset
    |=> s_q.count == $past(s_q.reload) && !RST_REQ)
    else $error("periodic mode did not restart from reload");

  chk_count_read: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    setup_rd && PADDR == wdc_pkg::OFF_COUNT |=> PRDATA == $past(s_q.count))
    else $error("count read returned a stale value");

  chk_reset_values: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    !s_q.booted |-> s_q.count == wdc_pkg::RST_COUNT
      && s_q.control == wdc_pkg::RST_CONTROL)
    else $error("timeout setup after reset is not the default");

  chk_decrement: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    count_step && s_q.count > 32'h0000_0001 |=> s_q.count == $past(s_q.count) - 32'h0000_0001)
    else $error("counter did not drop by one on a tick");

  chk_no_tick_hold: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    !tick && !wr_reload |=> s_q.count == $past(s_q.count))
    else $error("counter moved without a tick");

  chk_stopped_hold: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    !run && !load_now |=> s_q.count == $past(s_q.count))
    else $error("stopped counter moved");

  chk_reload_restart: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    load_now |=> !tick)
    else $error("prescaler ticked right after a permitted reload");

  chk_reload_stored: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    wr_reload |=> s_q.reload == $past(PWDATA))
    else $error("reload value was not stored");

  chk_control_write: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    wr_control |=> s_q.control == ($past(PWDATA) & wdc_pkg::CON_MASK))
    else $error("control write did not take the masked value");

  chk_periodic_no_reset: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    count_step && s_q.count == 32'h0000_0001 && !act_reset |=> !RST_REQ)
    else $error("periodic mode requested a reset");

  ////////////////////////////////////////////////////////////////////////////
  // timeout action checks, then enable write and read data hold

  chk_rst_req_sticky: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    RST_REQ |=> RST_REQ)
    else $error("reset request dropped before system reset");

  chk_rst_req_cause: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    !RST_REQ && !(count_step && s_q.count == 32'h0000_0001 && act_reset) |=> !RST_REQ)
    else $error("reset request rose without a timeout");

  chk_count_frozen: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    s_q.rst_req && !load_now |=> s_q.count == $past(s_q.count))
    else $error("count moved after the reset request");

  chk_status_set: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    ev_set[wdc_pkg::EV_TIMEOUT] |=> s_q.status[wdc_pkg::EV_TIMEOUT])
    else $error("timeout event did not set the status bit");

  chk_status_sticky: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    s_q.status[wdc_pkg::EV_TIMEOUT] && !(wr_clear && PWDATA[wdc_pkg::EV_TIMEOUT])
    |=> s_q.status[wdc_pkg::EV_TIMEOUT])
    else $error("status bit fell without a clear");

  chk_clear_effect: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    wr_clear && PWDATA[wdc_pkg::EV_TIMEOUT] && !ev_set[wdc_pkg::EV_TIMEOUT]
    |=> !s_q.status[wdc_pkg::EV_TIMEOUT])
    else $error("clear write left the status bit set");

  chk_no_false_event: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    !s_q.status[wdc_pkg::EV_TIMEOUT] && !(count_step && s_q.count == 32'h0000_0001)
    |=> !s_q.status[wdc_pkg::EV_TIMEOUT])
    else $error("status bit rose without a timeout");

  chk_enable_write: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    wr_enable |=> s_q.enable == $past(PWDATA[NUM_EV-1:0]))
    else $error("enable write did not land");

  chk_prdata_hold: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    !setup_rd |=> $stable(PRDATA))
    else $error("read data changed outside a read setup");

  ////////////////////////////////////////////////////////////////////////////
  // default timeout watch, used by the checks only

  // any control or reload write may move the expiry, so the watch gives up then
  logic [31:0] since_rst_q;
  logic        untouched_q;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      since_rst_q <= 32'h0000_0000;
      untouched_q <= 1'b1;
    end else begin
      if (since_rst_q != 32'hFFFF_FFFF) begin
        since_rst_q <= since_rst_q + 32'h0000_0001;
      end
      if (wr_control || wr_reload) begin
        untouched_q <= 1'b0;
      end
    end
  end

  chk_default_expiry: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    untouched_q && $rose(RST_REQ) |-> since_rst_q == DEFAULT_EXPIRY)
    else $error("default timeout did not expire on time");

endmodule
`default_nettype wire

/* tb/wdc_tb_top.sv */
// wdc_tb_top: self-checking bench for the watchdog down counter
`timescale 1ns/10ps
`default_nettype none
module wdc_tb_top;
  // one count tick per clock at select 7, so the reset count expires in ~65535 cycles
  localparam int unsigned TCYC = 32'h0001_0000;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        rst_req;
  logic [31:0] lfsr    = 32'h0000_30C6;
  logic [31:0] got;
  logic [64:0] note;
  logic [64:0] exp_q[$];
  int          fails   = 0;
  int          checks  = 0;

  wdc_top #(.TIMEOUT_CYC(TCYC)) i_dut (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .RST_REQ(rst_req)
  );

  always #5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] next_rand(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one apb transfer; the note holds {error, data mask, data}
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic err);
    @(posedge ref_clk);
    exp_q.push_back({err, m, d});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    got = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, e, 32'hFFFF_FFFF, 1'b0);
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
  endtask

  // sampled on the falling edge so the flops have settled
  task automatic wait_sig(input logic use_rst, input int lim, output int n);
    n = 0;
    while ((use_rst ? rst_req : irq) !== 1'b1 && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    if (psel && penable && pready) begin
      if (exp_q.size() == 0) begin
        check(32'h0, 32'h1);
      end else begin
        note = exp_q.pop_front();
        check({31'h0, pslverr}, {31'h0, note[64]});
        if (note[63:32] != 32'h0) begin
          check(prdata & note[63:32], note[31:0]);
        end
      end
    end
  end

  initial begin
    repeat (90000) @(posedge ref_clk);
    fails++;
    report_and_stop();
  end

  initial begin
    int n;
    do_reset();
    rd(wdc_pkg::OFF_CONTROL, 32'h0000_805C);
    rd(wdc_pkg::OFF_RELOAD, 32'h0);
    rd(wdc_pkg::OFF_STATUS, 32'h0);
    rd(wdc_pkg::OFF_ENABLE, 32'h0);
    xfer(1'b0, 8'h18, 32'h0, 32'hFFFF_FFFF, 1'b1);
    xfer(1'b1, 8'h1C, lfsr, 32'h0, 1'b1);
    // stopped, load permitted
    wr(wdc_pkg::OFF_CONTROL, 32'h0000_0020);
    wr(wdc_pkg::OFF_RELOAD, 32'h0000_1234);
    rd(wdc_pkg::OFF_COUNT, 32'h0000_1234);
    wr(wdc_pkg::OFF_CONTROL, 32'h0);
    wr(wdc_pkg::OFF_RELOAD, 32'h0000_0055);
    wr(wdc_pkg::OFF_COUNT, 32'h0000_0077);
    rd(wdc_pkg::OFF_COUNT, 32'h0000_1234);
    for (int a = 0; a < 6; a++) begin
      lfsr = next_rand(lfsr);
      wr(wdc_pkg::OFF_CONTROL, lfsr & 32'hFFFF_7FFF);
      rd(wdc_pkg::OFF_CONTROL, lfsr & 32'h0000_007C);
      wr(wdc_pkg::OFF_CONTROL, 32'h0000_0020);
      wr(wdc_pkg::OFF_RELOAD, lfsr);
      rd(wdc_pkg::OFF_COUNT, lfsr);
    end
    // running at select 0; successive read latches are three clocks apart
    wr(wdc_pkg::OFF_RELOAD, 32'h0000_1000);
    wr(wdc_pkg::OFF_CONTROL, 32'h0000_8020);
    xfer(1'b0, wdc_pkg::OFF_COUNT, 32'h0, 32'h0, 1'b0);
    rd(wdc_pkg::OFF_COUNT, got - 32'd3);
    // reset action at select 0, kept alive by reloads every few clocks
    wr(wdc_pkg::OFF_CONTROL, 32'h0000_0060);
    wr(wdc_pkg::OFF_RELOAD, 32'h0000_0008);
    wr(wdc_pkg::OFF_CONTROL, 32'h0000_8060);
    repeat (6) wr(wdc_pkg::OFF_RELOAD, 32'h0000_0008);
    check({31'h0, rst_req}, 32'h0);
    rd(wdc_pkg::OFF_STATUS, 32'h0);
    // periodic interrupt from a count of 5
    wr(wdc_pkg::OFF_CONTROL, 32'h0000_0020);
    wr(wdc_pkg::OFF_RELOAD, 32'h0000_0005);
    wr(wdc_pkg::OFF_ENABLE, 32'h1);
    rd(wdc_pkg::OFF_ENABLE, 32'h1);
    wr(wdc_pkg::OFF_CONTROL, 32'h0000_8020);
    wait_sig(1'b0, 40, n);
    check({31'h0, (n >= 3 && n <= 12)}, 32'h1);
    check({31'h0, rst_req}, 32'h0);
    wr(wdc_pkg::OFF_ENABLE, 32'h0);
    repeat (2) @(negedge ref_clk);
    check({31'h0, irq}, 32'h0);
    rd(wdc_pkg::OFF_STATUS, 32'h1);
    wr(wdc_pkg::OFF_ENABLE, 32'h1);
    repeat (2) @(negedge ref_clk);
    check({31'h0, irq}, 32'h1);
    wr(wdc_pkg::OFF_CONTROL, 32'h0000_0020);
    wr(wdc_pkg::OFF_CLEAR, 32'h1);
    rd(wdc_pkg::OFF_STATUS, 32'h0);
    repeat (2) @(negedge ref_clk);
    check({31'h0, irq}, 32'h0);
    // second reset in mid-run, then the default timeout with no setup
    @(posedge ref_clk);
    do_reset();
    wait_sig(1'b1, 70000, n);
    check({31'h0, (n >= 65500 && n <= 65600)}, 32'h1);
    check({31'h0, irq}, 32'h0);
    rd(wdc_pkg::OFF_COUNT, 32'h0);
    rd(wdc_pkg::OFF_STATUS, 32'h1);
    check({31'h0, rst_req}, 32'h1);
    report_and_stop();
  end
endmodule
`default_nettype wire
